// File: common/jtp_pkg.sv
// Package for the test access port: states, instruction codes, widths
package jtp_pkg;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jtp_state_t;

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int          IR_W           = 3;
  localparam logic [2:0]  INS_EXTEST     = 3'h0;
  localparam logic [2:0]  INS_IDCODE     = 3'h1;
  localparam logic [2:0]  INS_SAMPLE_Z   = 3'h2;
  localparam logic [2:0]  INS_SAMPLE     = 3'h4;
  localparam logic [2:0]  INS_BYPASS     = 3'h7;
  localparam logic [1:0]  IR_CAPTURE_PAT = 2'h1;
  localparam logic [2:0]  IR_RESET_VAL   = INS_IDCODE;

  // ----------------------------------------------------------------
  // Data registers and reset TMS count
  // ----------------------------------------------------------------
  localparam int          ID_W           = 32;
  localparam int          BSR_W_DEF      = 16;
  localparam int          RESET_TMS_CNT  = 5;

endpackage : jtp_pkg

// File: core/jtp_edge_sync.sv
// Two-flop synchroniser with edge detection for the test clock pin
`timescale 1ns/10ps
module jtp_edge_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } jtp_sync_t;

  jtp_sync_t s_q;
  jtp_sync_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = i_pin;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.sync;
  assign o_rise  = s_q.sync & ~s_q.last;
  assign o_fall  = ~s_q.sync & s_q.last;

endmodule : jtp_edge_sync

// File: core/jtp_tap.sv
// Boundary-scan test access port controller with IR, bypass, ID and scan registers
`timescale 1ns/10ps

// Functional notes
// - The port follows the 1149.1-2001 controller sequencing and register behaviour.
// - TMS and TDI are sampled only at a detected rising edge of the test clock.
// - TDO and its enable change only at a detected falling edge of the test clock.
// - State changes depend only on TMS taken at each rising test clock edge.
// - An unconnected TMS reads as high through the pad pull-up.
// - An unconnected TDI reads as high through the pad pull-up.
// - Exactly one register, chosen by the current instruction, sits between TDI and TDO.
// - TDI enters the most significant bit of the selected register.
// - TDO shows the least significant bit, so data leaves LSB first.
// - TDO drives only in the shift states and is released otherwise.
// - Five rising edges with TMS high always reach the reset state.
// - A port reset touches nothing of the memory path besides the port itself.
// - Power-up reset puts the controller in reset with TDO released.
// - The three-bit instruction register holds IDCODE after power-up and in reset.
// - Capture of the instruction path loads 01 into the two low bits.
module jtp_tap
  import jtp_pkg::*;
#(
  parameter int          BSR_W   = BSR_W_DEF,
  parameter logic [31:0] ID_CODE = 32'h1234_5679 // Arbitrary value
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_tck,
  input  wire logic             i_tms,
  input  wire logic             i_tms_pull_en,
  input  wire logic             i_tdi,
  input  wire logic             i_tdi_pull_en,
  input  wire logic [BSR_W-1:0] i_bsr_pins,
  output logic                  o_tdo,
  output logic                  o_tdo_oen,
  output logic [BSR_W-1:0]      o_bsr_update,
  output logic                  o_extest,
  output logic                  o_sample_z,
  output logic                  o_tap_reset
);

  // Boundary register needs a data cell and the bus enable cell
  if (BSR_W < 2) begin : g_bsr_w_chk
    $error("BSR_W must be at least 2");
  end

  localparam logic [2:0] TMS_ONES_MAX = 3'(RESET_TMS_CNT);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic tck_rise;
  logic tck_fall;
  logic tms_m;
  logic tms_s;
  logic tdi_m;
  logic tdi_s;
  logic tms_pm;
  logic tms_ps;
  logic tdi_pm;
  logic tdi_ps;
  logic tms_eff;
  logic tdi_eff;

  jtp_edge_sync u_tck_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_pin     (i_tck),
    .o_level   (),
    .o_rise    (tck_rise),
    .o_fall    (tck_fall)
  );

  // Pins and float flags each pass two flops; a floating pin reads as high
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tms_m  <= 1'b1;
      tms_s  <= 1'b1;
      tdi_m  <= 1'b1;
      tdi_s  <= 1'b1;
      tms_pm <= 1'b0;
      tms_ps <= 1'b0;
      tdi_pm <= 1'b0;
      tdi_ps <= 1'b0;
    end else begin
      tms_m  <= i_tms;
      tms_s  <= tms_m;
      tdi_m  <= i_tdi;
      tdi_s  <= tdi_m;
      tms_pm <= i_tms_pull_en;
      tms_ps <= tms_pm;
      tdi_pm <= i_tdi_pull_en;
      tdi_ps <= tdi_pm;
    end
  end

  assign tms_eff = tms_s | tms_ps;
  assign tdi_eff = tdi_s | tdi_ps;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    jtp_state_t       st;
    logic [IR_W-1:0]  ir_sh;
    logic [IR_W-1:0]  ir;
    logic             byp;
    logic [ID_W-1:0]  id_sh;
    logic [BSR_W-1:0] bsr_sh;
    logic [BSR_W-1:0] bsr_upd;
    logic             tdo;
    logic             oen;
  } jtp_tap_t;

  jtp_tap_t r_q;
  jtp_tap_t r_d;

  jtp_state_t nxt;
  logic       sel_lsb;

  // ----------------------------------------------------------------
  // Next state from TMS
  // ----------------------------------------------------------------
  always_comb begin
    nxt = r_q.st;
    case (r_q.st)
      ST_RESET:  nxt = tms_eff ? ST_RESET  : ST_IDLE;
      ST_IDLE:   nxt = tms_eff ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt = tms_eff ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt = tms_eff ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: nxt = tms_eff ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: nxt = tms_eff ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt = tms_eff ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt = tms_eff ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: nxt = tms_eff ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt = tms_eff ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: nxt = tms_eff ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: nxt = tms_eff ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: nxt = tms_eff ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt = tms_eff ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt = tms_eff ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: nxt = tms_eff ? ST_SEL_DR : ST_IDLE;
      default:   nxt = ST_RESET;
    endcase
  end

  // Serial output source
  always_comb begin
    sel_lsb = r_q.byp;
    if (r_q.st == ST_SHF_IR) begin
      sel_lsb = r_q.ir_sh[0];
    end else begin
      case (r_q.ir)
        INS_IDCODE:                      sel_lsb = r_q.id_sh[0];
        INS_EXTEST, INS_SAMPLE,
        INS_SAMPLE_Z:                    sel_lsb = r_q.bsr_sh[0];
        default:                         sel_lsb = r_q.byp;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register update on test clock edges
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    if (tck_rise) begin
      r_d.st = nxt;
      case (r_q.st)
        ST_RESET: begin
          r_d.ir = IR_RESET_VAL;
          r_d.bsr_upd = '0;
          r_d.bsr_upd[BSR_W-1] = 1'b1;
        end
        ST_CAP_IR: r_d.ir_sh = {1'b0, IR_CAPTURE_PAT};
        ST_SHF_IR: r_d.ir_sh = {tdi_eff, r_q.ir_sh[IR_W-1:1]};
        ST_UPD_IR: r_d.ir = r_q.ir_sh;
        ST_CAP_DR: begin
          r_d.byp = 1'b0;
          r_d.id_sh = ID_CODE;
          r_d.bsr_sh = i_bsr_pins;
        end
        ST_SHF_DR: begin
          case (r_q.ir)
            INS_IDCODE: r_d.id_sh = {tdi_eff, r_q.id_sh[ID_W-1:1]};
            INS_EXTEST, INS_SAMPLE, INS_SAMPLE_Z:
              r_d.bsr_sh = {tdi_eff, r_q.bsr_sh[BSR_W-1:1]};
            default: r_d.byp = tdi_eff;
          endcase
        end
        ST_UPD_DR: begin
          // Only EXTEST and SAMPLE/PRELOAD latch the scan cells
          if (r_q.ir == INS_EXTEST || r_q.ir == INS_SAMPLE) begin
            r_d.bsr_upd = r_q.bsr_sh;
          end
        end
        default: r_d.byp = r_q.byp;
      endcase
      // IR holds IDCODE as soon as reset is entered
      if (nxt == ST_RESET) begin
        r_d.ir = IR_RESET_VAL;
      end
    end
    // Enable follows the state held between the rise and this fall
    if (tck_fall) begin
      r_d.tdo = sel_lsb;
      r_d.oen = !(r_q.st == ST_SHF_DR || r_q.st == ST_SHF_IR);
    end
  end

  // Port reset only reaches port state
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_q         <= '0;
      r_q.st      <= ST_RESET;
      r_q.ir      <= IR_RESET_VAL;
      r_q.ir_sh   <= IR_RESET_VAL;
      r_q.bsr_upd <= {1'b1, {(BSR_W-1){1'b0}}};
      r_q.oen     <= 1'b1;
      r_q.tdo     <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_tdo        = r_q.tdo;
  assign o_tdo_oen    = r_q.oen;
  assign o_bsr_update = r_q.bsr_upd;
  assign o_extest     = (r_q.ir == INS_EXTEST);
  assign o_sample_z   = (r_q.ir == INS_SAMPLE_Z);
  assign o_tap_reset  = (r_q.st == ST_RESET);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Rises with TMS high, saturating at the reset count
  logic [2:0] ones_cnt;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ones_cnt <= '0;
    end else if (tck_rise) begin
      ones_cnt <= tms_eff ? ((ones_cnt == TMS_ONES_MAX) ? ones_cnt : ones_cnt + 3'h1) : 3'h0;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  five_ones_a: assert property (ones_cnt == TMS_ONES_MAX |-> r_q.st == ST_RESET)
    else $error("Five TMS highs did not reach reset");
  state_hold_a: assert property (!tck_rise |=> $stable(r_q.st))
    else $error("State moved without rising test clock");
  tdo_hold_a: assert property (!tck_fall |=> $stable(o_tdo) && $stable(o_tdo_oen))
    else $error("TDO changed without falling test clock");
  oen_shift_a: assert property (tck_fall && r_q.st != ST_SHF_DR && r_q.st != ST_SHF_IR |=> o_tdo_oen)
    else $error("TDO driven outside shift");
  ir_reset_a: assert property (r_q.st == ST_RESET && tck_rise |=> r_q.ir == IR_RESET_VAL)
    else $error("IR not IDCODE in reset");
  ir_cap_a: assert property (r_q.st == ST_CAP_IR && tck_rise |=> r_q.ir_sh[1:0] == IR_CAPTURE_PAT)
    else $error("IR capture pattern wrong");
  ir_update_a: assert property (tck_rise && r_q.st != ST_UPD_IR && nxt != ST_RESET && r_q.st != ST_RESET
                                |=> $stable(r_q.ir))
    else $error("IR changed outside update");
  tdo_lsb_a: assert property (tck_fall && r_q.st == ST_SHF_IR |=> o_tdo == $past(r_q.ir_sh[0]))
    else $error("TDO not IR lsb");
  ir_msb_a: assert property (tck_rise && r_q.st == ST_SHF_IR |=> r_q.ir_sh[IR_W-1] == $past(tdi_eff))
    else $error("TDI not into msb");
  byp_sel_a: assert property (tck_rise && r_q.st == ST_SHF_DR && r_q.ir == INS_BYPASS
                              |=> r_q.byp == $past(tdi_eff) && $stable(r_q.id_sh))
    else $error("Bypass path wrong");
  state_next_a: assert property (tck_rise |=> r_q.st == $past(nxt))
    else $error("State did not follow TMS");
  oen_drive_a: assert property (tck_fall && (r_q.st == ST_SHF_DR || r_q.st == ST_SHF_IR) |=> !o_tdo_oen)
    else $error("TDO not driven in shift");
  tdo_dr_lsb_a: assert property (tck_fall && r_q.st == ST_SHF_DR && r_q.ir == INS_IDCODE
                                 |=> o_tdo == $past(r_q.id_sh[0]))
    else $error("TDO not ID lsb");
  id_msb_a: assert property (tck_rise && r_q.st == ST_SHF_DR && r_q.ir == INS_IDCODE
                             |=> r_q.id_sh[ID_W-1] == $past(tdi_eff))
    else $error("TDI not into ID msb");
  bsr_msb_a: assert property (tck_rise && r_q.st == ST_SHF_DR && r_q.ir == INS_SAMPLE
                              |=> r_q.bsr_sh[BSR_W-1] == $past(tdi_eff) && $stable(r_q.id_sh))
    else $error("Scan path wrong");
  dr_capture_a: assert property (tck_rise && r_q.st == ST_CAP_DR
                                 |=> r_q.id_sh == ID_CODE && !r_q.byp && r_q.bsr_sh == $past(i_bsr_pins))
    else $error("Data capture wrong");
  bsr_preset_a: assert property (tck_rise && r_q.st == ST_RESET |=> r_q.bsr_upd[BSR_W-1])
    else $error("Bus enable cell not preset");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  shift_dr_c: cover property (r_q.st == ST_SHF_DR && tck_rise);
  upd_ir_c: cover property (r_q.st == ST_UPD_IR && tck_rise);
  five_c: cover property (ones_cnt == TMS_ONES_MAX);
  shift_ir_c: cover property (r_q.st == ST_SHF_IR && tck_rise);
  bsr_upd_c: cover property (r_q.st == ST_UPD_DR && tck_rise && r_q.ir == INS_SAMPLE);

endmodule : jtp_tap

// File: test/jtp_master_model.sv
// Board-side scan controller model driving the test port pins
`timescale 1ns/10ps
module jtp_master_model (
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tms_pull_en,
  output logic      o_tdi,
  output logic      o_tdi_pull_en,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oen
);
  initial begin
    o_tck         = 1'h0;
    o_tms         = 1'h1;
    o_tdi         = 1'h1;
    o_tms_pull_en = 1'h0;
    o_tdi_pull_en = 1'h0;
  end

  // ----------------------------------------------------------------
  // One test clock period, 80 ns; pins move only while clock is low
  // ----------------------------------------------------------------
  task automatic clock_bit(input logic tms, input logic tdi, input logic tms_flt, input logic tdi_flt,
                           output logic tdo, output logic oen);
    o_tms         = tms & ~tms_flt;
    o_tdi         = tdi & ~tdi_flt;
    o_tms_pull_en = tms_flt;
    o_tdi_pull_en = tdi_flt;
    #40;
    tdo   = i_tdo;
    oen   = i_tdo_oen;
    o_tck = 1'h1;
    #40;
    o_tck = 1'h0;
  endtask : clock_bit
endmodule : jtp_master_model

// File: test/test_jtp_tap.sv
// Self-checking bench for the test access port controller
`timescale 1ns/10ps
module test_jtp_tap;
  import jtp_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h1357_9bdf; // Arbitrary value

  logic       i_ref_clk = 1'h0;
  logic       i_resetn;
  logic       tck, tms, tms_pull_en, tdi, tdi_pull_en;
  logic [7:0] i_bsr_pins;
  logic       o_tdo, o_tdo_oen, o_extest, o_sample_z, o_tap_reset;
  logic [7:0] o_bsr_update;
  int         n_fail = 0;
  int         total_checks = 0;
  logic [31:0] d;

  always #2.5 i_ref_clk = ~i_ref_clk;

  jtp_tap #(.BSR_W(8), .ID_CODE(ID_VAL)) i_jtp_tap (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_tck(tck), .i_tms(tms), .i_tms_pull_en(tms_pull_en),
    .i_tdi(tdi), .i_tdi_pull_en(tdi_pull_en), .i_bsr_pins(i_bsr_pins), .o_tdo(o_tdo), .o_tdo_oen(o_tdo_oen),
    .o_bsr_update(o_bsr_update), .o_extest(o_extest), .o_sample_z(o_sample_z), .o_tap_reset(o_tap_reset));

  jtp_master_model i_jtp_master_model (
    .o_tck(tck), .o_tms(tms), .o_tms_pull_en(tms_pull_en), .o_tdi(tdi), .o_tdi_pull_en(tdi_pull_en),
    .i_tdo(o_tdo), .i_tdo_oen(o_tdo_oen));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic tick(input logic m, input logic tms_flt = 1'h0);
    logic tdo, oen;
    i_jtp_master_model.clock_bit(m, 1'h0, tms_flt, 1'h0, tdo, oen);
  endtask : tick

  // From idle: shift n bits through IR or DR, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic flt,
                      output logic [31:0] dout);
    logic tdo, oen;
    dout = 32'h0000_0000;
    tick(1'h1);
    if (ir)
      tick(1'h1);
    tick(1'h0);
    tick(1'h0);
    for (int i = 0; i < n; i++) begin
      i_jtp_master_model.clock_bit(i == n - 1, din[i], 1'h0, flt, tdo, oen);
      dout[i] = tdo;
      check({31'h0, oen}, 32'h0000_0000);
    end
    tick(1'h1);
    tick(1'h0);
    i_jtp_master_model.clock_bit(1'h0, 1'h0, 1'h0, 1'h0, tdo, oen);
    check({31'h0, oen}, 32'h0000_0001);
  endtask : scan

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    check({31'h0, o_tap_reset}, 32'h0000_0001);
    check({31'h0, o_tdo_oen}, 32'h0000_0001);
    check({24'h0, o_bsr_update}, 32'h0000_0080);
    tick(1'h0);
    scan(1'h0, 32, 32'h0000_0000, 1'h0, d);
    check(d, ID_VAL);
  endtask : t_power_up
  task automatic t_bypass(input logic [2:0] code);
    scan(1'h1, 3, {29'h0, code}, 1'h0, d);
    check(d, 32'h0000_0001);
    scan(1'h0, 4, 32'h0000_000d, 1'h0, d);
    check(d, 32'h0000_000a);
  endtask : t_bypass
  task automatic t_float_reset();
    repeat (5) tick(1'h0, 1'h1);
    check({31'h0, o_tap_reset}, 32'h0000_0001);
    tick(1'h0);
    scan(1'h0, 32, 32'h0000_0000, 1'h0, d);
    check(d, ID_VAL);
    scan(1'h1, 3, {29'h0, INS_BYPASS}, 1'h0, d);
    scan(1'h0, 4, 32'h0000_0000, 1'h1, d);
    check(d, 32'h0000_000e);
  endtask : t_float_reset
  task automatic t_bsr();
    scan(1'h1, 3, {29'h0, INS_SAMPLE}, 1'h0, d);
    check({31'h0, o_extest}, 32'h0000_0000);
    scan(1'h0, 8, 32'h0000_003c, 1'h0, d);
    check(d, 32'h0000_00a5);
    check({24'h0, o_bsr_update}, 32'h0000_003c);
    scan(1'h1, 3, {29'h0, INS_EXTEST}, 1'h0, d);
    check({31'h0, o_extest}, 32'h0000_0001);
    scan(1'h1, 3, {29'h0, INS_SAMPLE_Z}, 1'h0, d);
    check({30'h0, o_sample_z, o_extest}, 32'h0000_0002);
    repeat (100) @(negedge i_ref_clk);
    check({30'h0, o_sample_z, o_tap_reset}, 32'h0000_0002);
    repeat (5) tick(1'h1);
    check({28'h0, o_bsr_update[7], o_sample_z, o_extest, o_tap_reset}, 32'h0000_0009);
  endtask : t_bsr

  initial begin
    i_resetn   = 1'h0;
    i_bsr_pins = 8'ha5;
    repeat (5) @(negedge i_ref_clk);
    i_resetn = 1'h1;
    @(negedge i_ref_clk);
    t_power_up();
    t_bypass(INS_BYPASS);
    t_bypass(3'h5);
    t_float_reset();
    t_bsr();
    stop_test();
  end

  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
endmodule : test_jtp_tap
